// ==== cst_pkg.sv ====
package cst_pkg;

	// register indices on the plain register port
	localparam logic [3:0] CST_ADDR_SD_CTRL = 4'h0;
	localparam logic [3:0] CST_ADDR_SD_SRC = 4'h1;
	localparam logic [3:0] CST_ADDR_DB_RISE = 4'h2;
	localparam logic [3:0] CST_ADDR_DB_FALL = 4'h3;
	localparam logic [3:0] CST_ADDR_BK_RISE = 4'h4;
	localparam logic [3:0] CST_ADDR_BK_FALL = 4'h5;
	localparam logic [3:0] CST_ADDR_PH_RISE = 4'h6;
	localparam logic [3:0] CST_ADDR_PH_FALL = 4'h7;
	localparam logic [3:0] CST_ADDR_GEN_A = 4'h8;
	localparam logic [3:0] CST_ADDR_GEN_B = 4'h9;
	localparam logic [3:0] CST_ADDR_INT_STAT = 4'ha;
	localparam logic [3:0] CST_ADDR_INT_MASK = 4'hb;

	// shutdown control fields
	localparam int CST_SD_STATUS_BIT = 7;
	localparam int CST_SD_ARS_BIT = 6;
	localparam int CST_SD_LVL1_LSB = 4;
	localparam int CST_SD_LVL0_LSB = 2;

	// shutdown source enable fields
	localparam int CST_SRC_LT2_BIT = 4;
	localparam int CST_SRC_LT1_BIT = 3;
	localparam int CST_SRC_CMP2_BIT = 2;
	localparam int CST_SRC_CMP1_BIT = 1;
	localparam int CST_SRC_FLT_BIT = 0;
	localparam int CST_SRC_W = 5;

	// generator control fields
	localparam int CST_GA_POL1_BIT = 4;
	localparam int CST_GA_POL0_BIT = 3;
	localparam int CST_GB_RDBTS_BIT = 7;
	localparam int CST_GB_FDBTS_BIT = 6;

	// interrupt status bits
	localparam int CST_INT_SD_BIT = 0;
	localparam int CST_INT_RISE_BIT = 1;
	localparam int CST_INT_FALL_BIT = 2;
	localparam int CST_INT_W = 3;

	// shutdown drive levels
	localparam logic [1:0] CST_LVL_TRI = 2'h3;
	localparam logic [1:0] CST_LVL_INACT = 2'h2;
	localparam logic [1:0] CST_LVL_ONE = 2'h1;
	localparam logic [1:0] CST_LVL_ZERO = 2'h0;

	localparam int CST_CNT_W = 4;
	localparam logic [7:0] CST_RST_BYTE = 8'h00;
	localparam logic [3:0] CST_RST_CNT = 4'h0;

	typedef enum logic [2:0] {
		CST_PH_OFF,
		CST_PH_RISE_DB,
		CST_PH_HIGH,
		CST_PH_FALL_DB,
		CST_PH_LOW
	} cst_phase_t;

endpackage

// ==== cst_power_stage.sv ====
`timescale 1ns/1ns
module cst_power_stage (
	input wire logic i_sys_clk,
	input wire logic i_gate0,
	input wire logic i_gate0_oe_n,
	input wire logic i_gate1,
	input wire logic i_gate1_oe_n,
	output logic o_level0,
	output logic o_level1
);
	logic lvl0_reg = 1'h0;
	logic lvl1_reg = 1'h0;

	// a floating gate has no pull, so it wanders each cycle
	always_ff @(posedge i_sys_clk) begin
		lvl0_reg <= i_gate0_oe_n ? ~lvl0_reg : i_gate0;
		lvl1_reg <= i_gate1_oe_n ? ~lvl1_reg : i_gate1;
	end
	assign o_level0 = lvl0_reg;
	assign o_level1 = lvl1_reg;
endmodule // cst_power_stage

// ==== cst_top.sv ====
`timescale 1ns/1ns
// Overview of operation
// - shutdown status bit 7 reads one while outputs are in shutdown
// - during shutdown each output follows its 2-bit level field
// - limit timer count equal to period forces shutdown when enabled
// - enabled comparator output low forces shutdown
// - enabled fault pin low forces shutdown
// - rising event delays primary output by rising dead-band count
// - falling event delays complementary output by falling dead-band count
// - rising event blanks falling inputs for rising blanking count
// - falling event blanks rising inputs for falling blanking count
// - edge-mode rising event waits rising phase count generator periods
// - edge-mode falling event waits falling phase count generator periods
// - count registers reset only by power-on, kept across other resets
// - unused upper register bits read zero, writes ignored
// - edge mode acts once per rising edge of the event and adds the phase delay; level mode re-requests every cycle the event is high
module cst_top
	import cst_pkg::*;
#(
	parameter int GEN_DIV = 2,
	parameter int DIV_W = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_por,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_rise_evt,
	input wire logic i_rise_edge_mode,
	input wire logic i_fall_evt,
	input wire logic i_fall_edge_mode,
	input wire logic i_cmp1,
	input wire logic i_cmp2,
	input wire logic i_fault_input_pin_n,
	input wire logic [7:0] i_limit_timer1_count,
	input wire logic [7:0] i_limit_timer1_period,
	input wire logic [7:0] i_limit_timer2_count,
	input wire logic [7:0] i_limit_timer2_period,
	output logic o_primary_output_pin,
	output logic o_primary_output_pin_oe_n,
	output logic o_complementary_output_pin,
	output logic o_complementary_output_pin_oe_n,
	output logic o_irq
);

	if (GEN_DIV < 1 || DIV_W > 16
		|| GEN_DIV >= (1 << DIV_W)) begin : g_div_chk
		$error("cst_top: GEN_DIV does not fit DIV_W");
	end

	localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(GEN_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = '0;
	localparam logic [3:0] CNT_ONE = 4'h1;

	// count values survive ordinary resets, so they live apart
	typedef struct packed {
		logic [3:0] rise_deadband_value;
		logic [3:0] fall_deadband_value;
		logic [3:0] rise_blanking_value;
		logic [3:0] fall_blanking_value;
		logic [3:0] rise_phase_value;
		logic [3:0] fall_phase_value;
	} cst_cfg_t;

	typedef struct packed {
		logic shutdown_status_bit;
		logic auto_restart_enable;
		logic [1:0] out1_shutdown_level;
		logic [1:0] out0_shutdown_level;
		logic [CST_SRC_W-1:0] src_en;
		logic pol1;
		logic pol0;
		logic rise_deadband_source_select;
		logic fall_deadband_source_select;
		cst_phase_t phase;
		logic [3:0] db_cnt;
		logic [3:0] blank_fall_cnt;
		logic [3:0] blank_rise_cnt;
		logic rise_ph_busy;
		logic [3:0] rise_ph_cnt;
		logic fall_ph_busy;
		logic [3:0] fall_ph_cnt;
		logic rise_prev;
		logic fall_prev;
		logic [DIV_W-1:0] div_cnt;
		logic [CST_INT_W-1:0] int_stat;
		logic [CST_INT_W-1:0] int_mask;
		logic [7:0] rdata;
		logic out0;
		logic out0_oe_n;
		logic out1;
		logic out1_oe_n;
		logic irq;
	} cst_state_t;

	cst_cfg_t cfg_reg;
	cst_cfg_t cfg_next;
	cst_state_t st_reg;
	cst_state_t st_next;

	localparam cst_cfg_t CFG_RST = '{
		rise_deadband_value: CST_RST_CNT,
		fall_deadband_value: CST_RST_CNT,
		rise_blanking_value: CST_RST_CNT,
		fall_blanking_value: CST_RST_CNT,
		rise_phase_value: CST_RST_CNT,
		fall_phase_value: CST_RST_CNT
	};

	localparam cst_state_t ST_RST = '{
		shutdown_status_bit: 1'b0,
		auto_restart_enable: 1'b0,
		out1_shutdown_level: CST_LVL_ZERO,
		out0_shutdown_level: CST_LVL_ZERO,
		src_en: '0,
		pol1: 1'b0,
		pol0: 1'b0,
		rise_deadband_source_select: 1'b0,
		fall_deadband_source_select: 1'b0,
		phase: CST_PH_OFF,
		db_cnt: CST_RST_CNT,
		blank_fall_cnt: CST_RST_CNT,
		blank_rise_cnt: CST_RST_CNT,
		rise_ph_busy: 1'b0,
		rise_ph_cnt: CST_RST_CNT,
		fall_ph_busy: 1'b0,
		fall_ph_cnt: CST_RST_CNT,
		rise_prev: 1'b0,
		fall_prev: 1'b0,
		div_cnt: DIV_ZERO,
		int_stat: '0,
		int_mask: '0,
		rdata: CST_RST_BYTE,
		out0: 1'b0,
		out0_oe_n: 1'b0,
		out1: 1'b0,
		out1_oe_n: 1'b0,
		irq: 1'b0
	};

	logic gen_tick;
	logic db_tick;
	logic lt1_hit;
	logic lt2_hit;
	logic sd_src;
	logic rise_req;
	logic fall_req;
	logic rise_acc;
	logic fall_acc;
	logic act0;
	logic act1;
	logic [CST_INT_W-1:0] int_set;
	logic [CST_INT_W-1:0] int_clr;

	always_comb begin
		cfg_next = cfg_reg;
		st_next = st_reg;
		int_set = '0;
		int_clr = '0;
		rise_req = 1'b0;
		fall_req = 1'b0;
		rise_acc = 1'b0;
		fall_acc = 1'b0;
		db_tick = 1'b0;

		// generator clock as an enable from the system clock
		gen_tick = (st_reg.div_cnt == DIV_ZERO);
		if (gen_tick) begin
			st_next.div_cnt = DIV_LOAD;
		end else begin
			st_next.div_cnt = st_reg.div_cnt - 1'b1;
		end

		// register writes; upper unused bits are simply dropped
		if (i_wr) begin
			if (i_addr == CST_ADDR_SD_CTRL) begin
				st_next.shutdown_status_bit = i_wdata[CST_SD_STATUS_BIT];
				st_next.auto_restart_enable = i_wdata[CST_SD_ARS_BIT];
				st_next.out1_shutdown_level =
					i_wdata[CST_SD_LVL1_LSB +: 2];
				st_next.out0_shutdown_level =
					i_wdata[CST_SD_LVL0_LSB +: 2];
			end else if (i_addr == CST_ADDR_SD_SRC) begin
				st_next.src_en = i_wdata[CST_SRC_W-1:0];
			end else if (i_addr == CST_ADDR_DB_RISE) begin
				cfg_next.rise_deadband_value = i_wdata[CST_CNT_W-1:0];
			end else if (i_addr == CST_ADDR_DB_FALL) begin
				cfg_next.fall_deadband_value = i_wdata[CST_CNT_W-1:0];
			end else if (i_addr == CST_ADDR_BK_RISE) begin
				cfg_next.rise_blanking_value = i_wdata[CST_CNT_W-1:0];
			end else if (i_addr == CST_ADDR_BK_FALL) begin
				cfg_next.fall_blanking_value = i_wdata[CST_CNT_W-1:0];
			end else if (i_addr == CST_ADDR_PH_RISE) begin
				cfg_next.rise_phase_value = i_wdata[CST_CNT_W-1:0];
			end else if (i_addr == CST_ADDR_PH_FALL) begin
				cfg_next.fall_phase_value = i_wdata[CST_CNT_W-1:0];
			end else if (i_addr == CST_ADDR_GEN_A) begin
				st_next.pol1 = i_wdata[CST_GA_POL1_BIT];
				st_next.pol0 = i_wdata[CST_GA_POL0_BIT];
			end else if (i_addr == CST_ADDR_GEN_B) begin
				st_next.rise_deadband_source_select =
					i_wdata[CST_GB_RDBTS_BIT];
				st_next.fall_deadband_source_select =
					i_wdata[CST_GB_FDBTS_BIT];
			end else if (i_addr == CST_ADDR_INT_STAT) begin
				int_clr = i_wdata[CST_INT_W-1:0];
			end else if (i_addr == CST_ADDR_INT_MASK) begin
				st_next.int_mask = i_wdata[CST_INT_W-1:0];
			end
		end

		// shutdown sources, any one enabled source is enough
		lt1_hit = (i_limit_timer1_count == i_limit_timer1_period);
		lt2_hit = (i_limit_timer2_count == i_limit_timer2_period);
		sd_src = (st_reg.src_en[CST_SRC_LT2_BIT] & lt2_hit)
			| (st_reg.src_en[CST_SRC_LT1_BIT] & lt1_hit)
			| (st_reg.src_en[CST_SRC_CMP2_BIT] & ~i_cmp2)
			| (st_reg.src_en[CST_SRC_CMP1_BIT] & ~i_cmp1)
			| (st_reg.src_en[CST_SRC_FLT_BIT] & ~i_fault_input_pin_n);

		// rising request: edge mode goes through the phase delay
		st_next.rise_prev = i_rise_evt;
		if (i_rise_edge_mode) begin
			if (i_rise_evt && !st_reg.rise_prev) begin
				if (cfg_reg.rise_phase_value == CST_RST_CNT) begin
					rise_req = 1'b1;
				end else begin
					st_next.rise_ph_busy = 1'b1;
					st_next.rise_ph_cnt = cfg_reg.rise_phase_value;
				end
			end
		end else begin
			rise_req = i_rise_evt;
		end
		if (st_reg.rise_ph_busy && gen_tick) begin
			if (st_reg.rise_ph_cnt == CNT_ONE) begin
				rise_req = 1'b1;
				st_next.rise_ph_busy = 1'b0;
			end else begin
				st_next.rise_ph_cnt = st_reg.rise_ph_cnt - 1'b1;
			end
		end

		// falling request, same shape
		st_next.fall_prev = i_fall_evt;
		if (i_fall_edge_mode) begin
			if (i_fall_evt && !st_reg.fall_prev) begin
				if (cfg_reg.fall_phase_value == CST_RST_CNT) begin
					fall_req = 1'b1;
				end else begin
					st_next.fall_ph_busy = 1'b1;
					st_next.fall_ph_cnt = cfg_reg.fall_phase_value;
				end
			end
		end else begin
			fall_req = i_fall_evt;
		end
		if (st_reg.fall_ph_busy && gen_tick) begin
			if (st_reg.fall_ph_cnt == CNT_ONE) begin
				fall_req = 1'b1;
				st_next.fall_ph_busy = 1'b0;
			end else begin
				st_next.fall_ph_cnt = st_reg.fall_ph_cnt - 1'b1;
			end
		end

		// blanking windows count generator periods
		if (gen_tick && st_reg.blank_fall_cnt != CST_RST_CNT) begin
			st_next.blank_fall_cnt = st_reg.blank_fall_cnt - 1'b1;
		end
		if (gen_tick && st_reg.blank_rise_cnt != CST_RST_CNT) begin
			st_next.blank_rise_cnt = st_reg.blank_rise_cnt - 1'b1;
		end

		// a level request repeats every cycle, so only a change of half counts
		rise_acc = rise_req && st_reg.blank_rise_cnt == CST_RST_CNT
			&& st_reg.phase != CST_PH_RISE_DB
			&& st_reg.phase != CST_PH_HIGH;
		fall_acc = fall_req && !rise_acc
			&& st_reg.blank_fall_cnt == CST_RST_CNT
			&& st_reg.phase != CST_PH_FALL_DB
			&& st_reg.phase != CST_PH_LOW;

		case (st_reg.phase)
			CST_PH_RISE_DB: begin
				db_tick = st_reg.rise_deadband_source_select | gen_tick;
				if (db_tick) begin
					if (st_reg.db_cnt == CNT_ONE) begin
						st_next.phase = CST_PH_HIGH;
					end else begin
						st_next.db_cnt = st_reg.db_cnt - 1'b1;
					end
				end
			end
			CST_PH_FALL_DB: begin
				db_tick = st_reg.fall_deadband_source_select | gen_tick;
				if (db_tick) begin
					if (st_reg.db_cnt == CNT_ONE) begin
						st_next.phase = CST_PH_LOW;
					end else begin
						st_next.db_cnt = st_reg.db_cnt - 1'b1;
					end
				end
			end
			default: begin
				st_next.phase = st_reg.phase;
			end
		endcase

		// delay chain modelled as one element per system clock when the source select bit is set, else one per generator period
		if (rise_acc) begin
			st_next.blank_fall_cnt = cfg_reg.rise_blanking_value;
			st_next.db_cnt = cfg_reg.rise_deadband_value;
			if (cfg_reg.rise_deadband_value == CST_RST_CNT) begin
				st_next.phase = CST_PH_HIGH;
			end else begin
				st_next.phase = CST_PH_RISE_DB;
			end
		end else if (fall_acc) begin
			st_next.blank_rise_cnt = cfg_reg.fall_blanking_value;
			st_next.db_cnt = cfg_reg.fall_deadband_value;
			if (cfg_reg.fall_deadband_value == CST_RST_CNT) begin
				st_next.phase = CST_PH_LOW;
			end else begin
				st_next.phase = CST_PH_FALL_DB;
			end
		end

		// auto-restart needs all sources gone and a fresh rise
		if (st_reg.shutdown_status_bit && st_reg.auto_restart_enable
			&& !sd_src && rise_acc) begin
			st_next.shutdown_status_bit = 1'b0;
		end
		// a live source beats a software clear in the same cycle
		if (sd_src) begin
			st_next.shutdown_status_bit = 1'b1;
		end
		int_set[CST_INT_SD_BIT] = sd_src & ~st_reg.shutdown_status_bit;
		int_set[CST_INT_RISE_BIT] = rise_acc;
		int_set[CST_INT_FALL_BIT] = fall_acc;
		st_next.int_stat = (st_reg.int_stat & ~int_clr) | int_set;
		st_next.irq = |(st_next.int_stat & st_next.int_mask);

		// outputs; inactive level equals the polarity bit
		act0 = (st_next.phase == CST_PH_HIGH);
		act1 = (st_next.phase == CST_PH_LOW);
		st_next.out0 = act0 ^ st_next.pol0;
		st_next.out1 = act1 ^ st_next.pol1;
		st_next.out0_oe_n = 1'b0;
		st_next.out1_oe_n = 1'b0;
		if (st_next.shutdown_status_bit) begin
			case (st_next.out0_shutdown_level)
				CST_LVL_TRI: st_next.out0_oe_n = 1'b1;
				CST_LVL_INACT: st_next.out0 = st_next.pol0;
				CST_LVL_ONE: st_next.out0 = 1'b1;
				default: st_next.out0 = 1'b0;
			endcase
			case (st_next.out1_shutdown_level)
				CST_LVL_TRI: st_next.out1_oe_n = 1'b1;
				CST_LVL_INACT: st_next.out1 = st_next.pol1;
				CST_LVL_ONE: st_next.out1 = 1'b1;
				default: st_next.out1 = 1'b0;
			endcase
		end

		// read data stands for one cycle only
		st_next.rdata = CST_RST_BYTE;
		if (i_rd) begin
			if (i_addr == CST_ADDR_SD_CTRL) begin
				st_next.rdata[CST_SD_STATUS_BIT] =
					st_reg.shutdown_status_bit;
				st_next.rdata[CST_SD_ARS_BIT] = st_reg.auto_restart_enable;
				st_next.rdata[CST_SD_LVL1_LSB +: 2] =
					st_reg.out1_shutdown_level;
				st_next.rdata[CST_SD_LVL0_LSB +: 2] =
					st_reg.out0_shutdown_level;
			end else if (i_addr == CST_ADDR_SD_SRC) begin
				st_next.rdata[CST_SRC_W-1:0] = st_reg.src_en;
			end else if (i_addr == CST_ADDR_DB_RISE) begin
				st_next.rdata[CST_CNT_W-1:0] = cfg_reg.rise_deadband_value;
			end else if (i_addr == CST_ADDR_DB_FALL) begin
				st_next.rdata[CST_CNT_W-1:0] = cfg_reg.fall_deadband_value;
			end else if (i_addr == CST_ADDR_BK_RISE) begin
				st_next.rdata[CST_CNT_W-1:0] = cfg_reg.rise_blanking_value;
			end else if (i_addr == CST_ADDR_BK_FALL) begin
				st_next.rdata[CST_CNT_W-1:0] = cfg_reg.fall_blanking_value;
			end else if (i_addr == CST_ADDR_PH_RISE) begin
				st_next.rdata[CST_CNT_W-1:0] = cfg_reg.rise_phase_value;
			end else if (i_addr == CST_ADDR_PH_FALL) begin
				st_next.rdata[CST_CNT_W-1:0] = cfg_reg.fall_phase_value;
			end else if (i_addr == CST_ADDR_GEN_A) begin
				st_next.rdata[CST_GA_POL1_BIT] = st_reg.pol1;
				st_next.rdata[CST_GA_POL0_BIT] = st_reg.pol0;
			end else if (i_addr == CST_ADDR_GEN_B) begin
				st_next.rdata[CST_GB_RDBTS_BIT] =
					st_reg.rise_deadband_source_select;
				st_next.rdata[CST_GB_FDBTS_BIT] =
					st_reg.fall_deadband_source_select;
			end else if (i_addr == CST_ADDR_INT_STAT) begin
				st_next.rdata[CST_INT_W-1:0] = st_reg.int_stat;
			end else if (i_addr == CST_ADDR_INT_MASK) begin
				st_next.rdata[CST_INT_W-1:0] = st_reg.int_mask;
			end
		end
	end

	// only power-on clears the counts; i_rst leaves them alone
	always_ff @(posedge i_sys_clk or posedge i_por) begin
		if (i_por) begin
			cfg_reg <= CFG_RST;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst or posedge i_por) begin
		if (i_rst || i_por) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata = st_reg.rdata;
	assign o_primary_output_pin = st_reg.out0;
	assign o_primary_output_pin_oe_n = st_reg.out0_oe_n;
	assign o_complementary_output_pin = st_reg.out1;
	assign o_complementary_output_pin_oe_n = st_reg.out1_oe_n;
	assign o_irq = st_reg.irq;

endmodule // cst_top

// ==== cst_top_monitor.sv ====
`timescale 1ns/1ns
module cst_top_monitor
	import cst_pkg::*;
#(
	parameter int GEN_DIV = 2,
	parameter int DIV_W = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_por,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_cmp1,
	input wire logic i_cmp2,
	input wire logic i_fault_input_pin_n,
	input wire logic [7:0] i_limit_timer1_count,
	input wire logic [7:0] i_limit_timer1_period,
	input wire logic [7:0] i_limit_timer2_count,
	input wire logic [7:0] i_limit_timer2_period,
	input wire logic o_primary_output_pin,
	input wire logic o_primary_output_pin_oe_n,
	input wire logic o_complementary_output_pin,
	input wire logic o_complementary_output_pin_oe_n,
	input wire logic o_irq
);
	// mirrors of software writes, so drive levels can be predicted
	logic [7:0] ctl_reg, src_reg, gen_reg, msk_reg;
	logic [3:0] cnt_reg [8];
	logic [3:0] sel_cnt;
	logic [1:0] lv0, lv1;
	logic exp0, exp1, shut_ok, in_cnt, src_flt, src_cmp, src_tmr, any_src;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst || i_por);

	always_ff @(posedge i_sys_clk or posedge i_rst or posedge i_por) begin
		if (i_rst || i_por) begin
			ctl_reg <= 8'h00;
			src_reg <= 8'h00;
			gen_reg <= 8'h00;
			msk_reg <= 8'h00;
		end else if (i_wr) begin
			case (i_addr)
				CST_ADDR_SD_CTRL: ctl_reg <= i_wdata;
				CST_ADDR_SD_SRC: src_reg <= i_wdata;
				CST_ADDR_GEN_A: gen_reg <= i_wdata;
				CST_ADDR_INT_MASK: msk_reg <= i_wdata;
				default: ;
			endcase
		end
	end
	// counts survive the ordinary reset, only power-on clears them
	always_ff @(posedge i_sys_clk or posedge i_por) begin
		if (i_por) begin
			cnt_reg <= '{default: 4'h0};
		end else if (i_wr && in_cnt) begin
			cnt_reg[i_addr[2:0]] <= i_wdata[3:0];
		end
	end
	assign in_cnt = i_addr >= CST_ADDR_DB_RISE && i_addr <= CST_ADDR_PH_FALL;
	assign sel_cnt = cnt_reg[i_addr[2:0]];
	assign lv0 = ctl_reg[CST_SD_LVL0_LSB +: 2];
	assign lv1 = ctl_reg[CST_SD_LVL1_LSB +: 2];
	assign exp0 = (lv0 == CST_LVL_INACT) ? gen_reg[CST_GA_POL0_BIT]
		: (lv0 == CST_LVL_ONE);
	assign exp1 = (lv1 == CST_LVL_INACT) ? gen_reg[CST_GA_POL1_BIT]
		: (lv1 == CST_LVL_ONE);
	assign shut_ok = (o_primary_output_pin_oe_n == (lv0 == CST_LVL_TRI))
		&& (lv0 == CST_LVL_TRI || o_primary_output_pin == exp0)
		&& (o_complementary_output_pin_oe_n == (lv1 == CST_LVL_TRI))
		&& (lv1 == CST_LVL_TRI || o_complementary_output_pin == exp1);
	assign src_flt = src_reg[CST_SRC_FLT_BIT] && !i_fault_input_pin_n;
	assign src_cmp = (src_reg[CST_SRC_CMP1_BIT] && !i_cmp1)
		|| (src_reg[CST_SRC_CMP2_BIT] && !i_cmp2);
	assign src_tmr = (src_reg[CST_SRC_LT1_BIT]
		&& i_limit_timer1_count == i_limit_timer1_period)
		|| (src_reg[CST_SRC_LT2_BIT]
		&& i_limit_timer2_count == i_limit_timer2_period);
	assign any_src = src_flt || src_cmp || src_tmr;

	chk_fault_shut: assert property (
		src_flt |=> shut_ok) else $error("fault shutdown drive wrong");
	chk_cmp_shut: assert property (
		src_cmp |=> shut_ok) else $error("comparator shutdown drive wrong");
	chk_timer_shut: assert property (
		src_tmr |=> shut_ok) else $error("timer shutdown drive wrong");
	chk_status_read: assert property (
		i_rd && i_addr == CST_ADDR_SD_CTRL && $past(any_src)
		&& $past(any_src, 2) |=> o_rdata[CST_SD_STATUS_BIT])
		else $error("status bit not set in shutdown");
	chk_rdata_idle: assert property (
		!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
	chk_count_read: assert property (
		i_rd && in_cnt |=> o_rdata == {4'h0, $past(sel_cnt)})
		else $error("count register read wrong");
	chk_src_read: assert property (
		i_rd && i_addr == CST_ADDR_SD_SRC
		|=> o_rdata == {3'h0, $past(src_reg[4:0])})
		else $error("source enable read wrong");
	chk_irq_masked: assert property (
		msk_reg == 8'h00 && $past(msk_reg) == 8'h00 |-> !o_irq)
		else $error("interrupt raised while masked");
endmodule // cst_top_monitor

bind cst_top cst_top_monitor #(.GEN_DIV(GEN_DIV), .DIV_W(DIV_W)) u_mon (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_por(i_por),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_cmp1(i_cmp1), .i_cmp2(i_cmp2),
	.i_fault_input_pin_n(i_fault_input_pin_n),
	.i_limit_timer1_count(i_limit_timer1_count),
	.i_limit_timer1_period(i_limit_timer1_period),
	.i_limit_timer2_count(i_limit_timer2_count),
	.i_limit_timer2_period(i_limit_timer2_period),
	.o_primary_output_pin(o_primary_output_pin),
	.o_primary_output_pin_oe_n(o_primary_output_pin_oe_n),
	.o_complementary_output_pin(o_complementary_output_pin),
	.o_complementary_output_pin_oe_n(o_complementary_output_pin_oe_n),
	.o_irq(o_irq)
);

// ==== cst_top_tb_top.sv ====
`timescale 1ns/1ns
module cst_top_tb_top;
	import cst_pkg::*;
	localparam int GD = 2;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic por = 1'h1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic rise = 1'h0;
	logic rmode = 1'h0;
	logic fall = 1'h0;
	logic fmode = 1'h0;
	logic cmp1 = 1'h1;
	logic cmp2 = 1'h1;
	logic flt_n = 1'h1;
	logic [7:0] t1c = 8'h00;
	logic [7:0] t2c = 8'h00;
	logic [7:0] tp = 8'h01;
	logic [7:0] rdata;
	logic p0, p0_oe_n, p1, p1_oe_n, irq, g0, g1;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;

	cst_top #(.GEN_DIV(GD)) uut (
		.i_sys_clk(clk), .i_rst(rst), .i_por(por), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_rise_evt(rise), .i_rise_edge_mode(rmode),
		.i_fall_evt(fall), .i_fall_edge_mode(fmode),
		.i_cmp1(cmp1), .i_cmp2(cmp2), .i_fault_input_pin_n(flt_n),
		.i_limit_timer1_count(t1c), .i_limit_timer1_period(tp),
		.i_limit_timer2_count(t2c), .i_limit_timer2_period(tp),
		.o_primary_output_pin(p0), .o_primary_output_pin_oe_n(p0_oe_n),
		.o_complementary_output_pin(p1),
		.o_complementary_output_pin_oe_n(p1_oe_n), .o_irq(irq)
	);
	cst_power_stage u_stage (
		.i_sys_clk(clk), .i_gate0(p0), .i_gate0_oe_n(p0_oe_n),
		.i_gate1(p1), .i_gate1_oe_n(p1_oe_n), .o_level0(g0), .o_level1(g1)
	);

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e,
		input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(nm, e, rdata);
	endtask

	task automatic do_rst(input logic full);
		@(posedge clk);
		rst <= 1'h1;
		por <= full;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		por <= 1'h0;
	endtask

	task automatic set_src(input int k, input logic on);
		case (k)
			0: flt_n <= ~on;
			1: cmp1 <= ~on;
			2: cmp2 <= ~on;
			3: t1c <= on ? tp : 8'h00;
			default: t2c <= on ? tp : 8'h00;
		endcase
	endtask

	// cycles from event until the driven output turns active
	task automatic meas(input logic r, input logic em, output int n);
		@(posedge clk);
		rise <= r;
		rmode <= em;
		fall <= ~r;
		fmode <= em;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while ((r ? p0 : p1) !== 1'h1 && n < 80);
		@(posedge clk);
		rise <= 1'h0;
		fall <= 1'h0;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_regs;
		for (int a = 2; a < 8; a++) wr_reg(4'(a), 8'hf0 | 8'(a));
		for (int a = 2; a < 8; a++) rd_reg(4'(a), 8'(a), "count");
		wr_reg(CST_ADDR_SD_CTRL, 8'h7f);
		rd_reg(CST_ADDR_SD_CTRL, 8'h7c, "ctrl");
		wr_reg(CST_ADDR_SD_SRC, 8'he0);
		rd_reg(CST_ADDR_SD_SRC, 8'h00, "enables");
		rd_reg(4'hc, 8'h00, "unmapped");
		do_rst(1'h0);
		for (int a = 2; a < 8; a++) rd_reg(4'(a), 8'(a), "kept");
		rd_reg(CST_ADDR_SD_CTRL, 8'h00, "ctrl reset");
		do_rst(1'h1);
		rd_reg(CST_ADDR_DB_FALL, 8'h00, "count por");
	endtask

	task automatic t_levels;
		logic [1:0] lv;
		wr_reg(CST_ADDR_GEN_A, 8'h10);
		wr_reg(CST_ADDR_SD_SRC, 8'h01);
		for (int i = 0; i < 4; i++) begin
			lv = 2'(i);
			wr_reg(CST_ADDR_SD_CTRL, {2'h0, lv, lv, 2'h0});
			@(posedge clk);
			flt_n <= 1'h0;
			repeat (3) @(posedge clk);
			#1 chk("oe0", {7'h0, lv == CST_LVL_TRI}, {7'h0, p0_oe_n});
			chk("oe1", {7'h0, lv == CST_LVL_TRI}, {7'h0, p1_oe_n});
			if (lv != CST_LVL_TRI) begin
				chk("gate0", {7'h0, lv == CST_LVL_ONE}, {7'h0, g0});
				chk("gate1", {7'h0, lv != CST_LVL_ZERO}, {7'h0, g1});
			end
			rd_reg(CST_ADDR_SD_CTRL, {2'h2, lv, lv, 2'h0}, "status");
			@(posedge clk);
			flt_n <= 1'h1;
			wr_reg(CST_ADDR_SD_CTRL, 8'h00);
			rd_reg(CST_ADDR_SD_CTRL, 8'h00, "cleared");
		end
	endtask

	task automatic t_sources;
		for (int k = 0; k < 5; k++) begin
			wr_reg(CST_ADDR_SD_SRC, 8'h00);
			@(posedge clk);
			set_src(k, 1'h1);
			rd_reg(CST_ADDR_SD_CTRL, 8'h00, "disabled src");
			wr_reg(CST_ADDR_SD_SRC, 8'h1f);
			rd_reg(CST_ADDR_SD_CTRL, 8'h80, "enabled src");
			@(posedge clk);
			set_src(k, 1'h0);
			wr_reg(CST_ADDR_SD_SRC, 8'h00);
			wr_reg(CST_ADDR_SD_CTRL, 8'h00);
		end
	endtask

	task automatic t_timing;
		int n0, n1, f0, f1, e0, e1, h0, h1;
		wr_reg(CST_ADDR_GEN_A, 8'h00);
		wr_reg(CST_ADDR_GEN_B, 8'hc0);
		repeat (2) begin
			meas(1'h1, 1'h0, n0);
			meas(1'h0, 1'h0, f0);
		end
		wr_reg(CST_ADDR_DB_RISE, 8'h03);
		wr_reg(CST_ADDR_DB_FALL, 8'h05);
		meas(1'h1, 1'h0, n1);
		meas(1'h0, 1'h0, f1);
		chk("rise deadband", 8'h03, 8'(n1 - n0));
		chk("fall deadband", 8'h05, 8'(f1 - f0));
		wr_reg(CST_ADDR_GEN_B, 8'h00);
		meas(1'h1, 1'h0, n1);
		meas(1'h0, 1'h0, f1);
		chk("rise db ticks", 8'h01, 8'(n1 > 2 * GD + n0
			&& n1 <= 3 * GD + n0));
		chk("fall db ticks", 8'h01, 8'(f1 > 4 * GD + f0
			&& f1 <= 5 * GD + f0));
		wr_reg(CST_ADDR_DB_RISE, 8'h00);
		wr_reg(CST_ADDR_DB_FALL, 8'h00);
		meas(1'h1, 1'h1, e0);
		meas(1'h0, 1'h1, h0);
		chk("edge vs level", 8'(f0), 8'(h0));
		wr_reg(CST_ADDR_PH_RISE, 8'h03);
		wr_reg(CST_ADDR_PH_FALL, 8'h02);
		meas(1'h1, 1'h1, e1);
		meas(1'h0, 1'h1, h1);
		chk("rise phase", 8'h01, 8'(e1 - e0 > 2 * GD
			&& e1 - e0 <= 3 * GD + 1));
		chk("fall phase", 8'h01, 8'(h1 - h0 > GD
			&& h1 - h0 <= 2 * GD + 1));
		wr_reg(CST_ADDR_PH_RISE, 8'h00);
		wr_reg(CST_ADDR_PH_FALL, 8'h00);
	endtask

	task automatic t_blank;
		int n;
		wr_reg(CST_ADDR_BK_RISE, 8'h08);
		wr_reg(CST_ADDR_INT_MASK, 8'h00);
		wr_reg(CST_ADDR_INT_STAT, 8'h07);
		meas(1'h1, 1'h0, n);
		@(posedge clk);
		fall <= 1'h1;
		@(posedge clk);
		fall <= 1'h0;
		repeat (30) @(posedge clk);
		#1 chk("blanked fall", 8'h00, {7'h0, p1});
		rd_reg(CST_ADDR_INT_STAT, 8'h02, "int status");
		chk("irq masked", 8'h00, {7'h0, irq});
		wr_reg(CST_ADDR_INT_MASK, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk("irq raised", 8'h01, {7'h0, irq});
		wr_reg(CST_ADDR_INT_STAT, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", 8'h00, {7'h0, irq});
		wr_reg(CST_ADDR_BK_FALL, 8'h08);
		meas(1'h0, 1'h0, n);
		chk("fall after blank", 8'h01, 8'(n));
		@(posedge clk);
		rise <= 1'h1;
		@(posedge clk);
		rise <= 1'h0;
		repeat (30) @(posedge clk);
		#1 chk("blanked rise", 8'h00, {7'h0, p0});
	endtask

	task automatic t_restart;
		wr_reg(CST_ADDR_SD_SRC, 8'h01);
		wr_reg(CST_ADDR_SD_CTRL, 8'h40);
		@(posedge clk);
		flt_n <= 1'h0;
		@(posedge clk);
		flt_n <= 1'h1;
		rd_reg(CST_ADDR_SD_CTRL, 8'hc0, "latched");
		@(posedge clk);
		rise <= 1'h1;
		@(posedge clk);
		rise <= 1'h0;
		rd_reg(CST_ADDR_SD_CTRL, 8'h40, "restarted");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		por <= 1'h0;
		t_regs();
		t_levels();
		t_sources();
		t_timing();
		t_blank();
		t_restart();
		stop_test();
	end
endmodule // cst_top_tb_top
